// ### esr_engine.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module esr_engine #(
  parameter logic [31:0] UPPER_OFF = esr_pkg::UPPER_OFF_DEF
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rstn,
  input  wire logic [7:0]                 i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [31:0]                     o_rdata,
  output var esr_pkg::esr_mem_req_t       o_mem,
  input  wire logic                       i_mem_ack,
  input  wire logic [esr_pkg::LINE_W-1:0] i_mem_rdata,
  output logic                            o_busy,
  output logic                            o_done
);
  import esr_pkg::*;

  esr_st_t              q;
  esr_st_t              d;
  logic [LINE_W-1:0]    st_rd;
  logic [LINE_W-1:0]    st_pk;
  logic                 st_es;
  logic                 st_we;
  logic [LINE_W-1:0]    st_wd;
  logic [BE_W-1:0]      st_be;
  logic                 prof_on;
  logic                 prof_off;
  logic                 prof_en;
  esr_be_t              cb;
  logic [BE_W-1:0]      be_all;
  logic [BE_W-1:0]      be_sv;
  logic [BE_W-1:0]      be_ld;
  logic [BE_W-1:0]      be_in;
  logic [BE_W-1:0]      be_got;
  logic                 pend;

  // Byte lanes of each component in one line of the image
  function automatic esr_be_t comp_be(input logic [5:0]  idx,
                                      input logic [63:0] sel,
                                      input logic        m64,
                                      input logic        pnd,
                                      input logic        sv);
    esr_be_t r;
    r = '0;
    if (sel[C_X87]) begin
      if (idx == L_X87A) begin
        r.x87 = pnd ? BE_FULL : BE_X87A_NOPTR;
      end else if (idx == L_X87B) begin
        r.x87 = pnd ? BE_PTR_B : '0;
      end else if (idx >= L_STK0 && idx <= L_STK7) begin
        r.x87 = BE_ST;
      end
    end
    if (sel[C_VEC] && idx >= L_VEC0 && idx < L_UPR0) begin
      r.vec = (idx < L_VEC8 || m64) ? BE_FULL : '0;
    end
    if (sel[C_UPR] && idx >= L_UPR0 && idx < L_END) begin
      r.upr = (idx < L_UPR8 || m64) ? BE_FULL : '0;
    end
    if (idx == L_X87B && (sel[C_VEC] || sel[C_UPR])) begin
      r.mcs = sv ? BE_MCS_SV : BE_MCS_LD;
    end
    return r;
  endfunction : comp_be

  // Fixed slot per line, no compaction when components are skipped
  function automatic logic [31:0] line_addr(input logic [31:0] base,
                                            input logic [5:0]  idx);
    logic [31:0] a;
    if (idx < L_UPR0) begin
      a = base + {22'h0, idx, 4'h0};
    end else begin
      a = base + UPPER_OFF + {22'h0, 6'(idx - L_UPR0), 4'h0};
    end
    return a;
  endfunction : line_addr

  // Hardware init image; every line other than the first is zero
  function automatic logic [LINE_W-1:0] init_line(input logic [5:0] idx);
    logic [LINE_W-1:0] v;
    v = '0;
    if (idx == L_X87A) begin
      v[15:0]  = FPU_CTRL_INIT;
      v[31:16] = FPU_STAT_INIT;
      v[39:32] = FPU_TAG_INIT;
    end
    return v;
  endfunction : init_line

  function automatic logic [LINE_W-1:0] be_mask(input logic [BE_W-1:0] be);
    logic [LINE_W-1:0] m;
    for (int b = 0; b < BE_W; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction : be_mask

  esr_state_file #(
    .NL (NLINES)
  ) esr_state_file_inst (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_rd_idx  (q.line_idx),
    .o_rd_data (st_rd),
    .i_pk_idx  (q.peek_idx),
    .o_pk_data (st_pk),
    .o_fault_pend (st_es),
    .i_wr_en   (st_we),
    .i_wr_idx  (q.line_idx),
    .i_wr_data (st_wd),
    .i_wr_be   (st_be),
    .i_prof_on  (prof_on),
    .i_prof_off (prof_off),
    .o_prof_en  (prof_en)
  );

  always_comb begin
    d       = q;
    d.rdata = '0;
    d.done  = 1'b0;
    st_we   = 1'b0;
    st_wd   = '0;
    st_be   = '0;
    prof_on  = 1'b0;
    prof_off = 1'b0;
    // Restore reads line 0 pointers before the fault bit is known; init zeroes them all
    pend    = (!q.is_save && (q.line_idx == L_X87A || !q.spv[C_X87])) ? 1'b1 : st_es;
    cb      = comp_be(q.line_idx, q.sel, q.mode64, pend, q.is_save);
    be_all  = cb.x87 | cb.vec | cb.upr;
    be_sv   = be_all | cb.mcs;
    be_ld   = (q.spv[C_X87] ? cb.x87 : '0) | (q.spv[C_VEC] ? cb.vec : '0) |
              (q.spv[C_UPR] ? cb.upr : '0) | cb.mcs;
    be_in   = be_all & ~be_ld;
    be_got  = q.be_ld;
    if (q.line_idx == L_X87A && !i_mem_rdata[16+FPU_FAULT_BIT]) begin
      be_got = q.be_ld & ~BE_FULL | (q.be_ld & BE_X87A_NOPTR);
    end

    case (q.fsm)
      S_IDLE: begin
        d.busy = 1'b0;
      end
      S_HDR_RD: begin
        if (i_mem_ack) begin
          d.spv     = i_mem_rdata[63:0];
          d.mem.req = 1'b0;
          d.fsm     = S_LINE;
        end
      end
      S_LINE: begin
        if (q.line_idx == L_END) begin
          if (q.is_save) begin
            d.spv       = q.spv | (q.sel & SAVE_COMPS);
            d.mem.req   = 1'b1;
            d.mem.we    = 1'b1;
            d.mem.addr  = q.base + HDR_OFF;
            d.mem.wdata = {64'h0, q.spv | (q.sel & SAVE_COMPS)};
            d.mem.be    = BE_X87A_NOPTR;
            d.fsm       = S_HDR_WAIT;
          end else begin
            prof_off = q.sel[C_PROF] && !q.spv[C_PROF];
            d.busy  = 1'b0;
            d.done  = 1'b1;
            d.fsm   = S_IDLE;
          end
        end else if (q.is_save) begin
          if (be_sv != '0) begin
            d.mem.req   = 1'b1;
            d.mem.we    = 1'b1;
            d.mem.addr  = line_addr(q.base, q.line_idx);
            d.mem.wdata = st_rd;
            d.mem.be    = be_sv;
            d.fsm       = S_WR_WAIT;
          end else begin
            d.line_idx = q.line_idx + 6'h01;
          end
        end else if (be_ld != '0) begin
          d.mem.req  = 1'b1;
          d.mem.we   = 1'b0;
          d.mem.addr = line_addr(q.base, q.line_idx);
          d.mem.be   = be_ld;
          d.be_ld    = be_ld;
          d.be_in    = be_in;
          d.fsm      = S_RD_WAIT;
        end else begin
          st_we      = be_in != '0;
          st_wd      = init_line(q.line_idx);
          st_be      = be_in;
          d.line_idx = q.line_idx + 6'h01;
        end
      end
      S_RD_WAIT: begin
        if (i_mem_ack) begin
          st_we      = 1'b1;
          st_wd      = (i_mem_rdata & be_mask(be_got)) |
                       (init_line(q.line_idx) & be_mask(q.be_in));
          st_be      = be_got | q.be_in;
          d.mem.req  = 1'b0;
          d.line_idx = q.line_idx + 6'h01;
          d.fsm      = S_LINE;
        end
      end
      S_WR_WAIT: begin
        if (i_mem_ack) begin
          d.mem.req  = 1'b0;
          d.line_idx = q.line_idx + 6'h01;
          d.fsm      = S_LINE;
        end
      end
      S_HDR_WAIT: begin
        if (i_mem_ack) begin
          d.mem.req = 1'b0;
          d.busy    = 1'b0;
          d.done    = 1'b1;
          d.fsm     = S_IDLE;
        end
      end
      default: begin
        d.fsm = S_IDLE;
      end
    endcase

    // Configuration is frozen while an operation runs
    if (i_wr && q.fsm == S_IDLE) begin
      case (i_addr)
        A_CTRL: begin
          d.mode64 = i_wdata[2];
          prof_on  = i_wdata[3];
          if (i_wdata[0] || i_wdata[1]) begin
            d.is_save    = i_wdata[0];
            d.sel        = q.imask & q.fem;
            d.line_idx   = L_X87A;
            d.busy       = 1'b1;
            d.mem.req    = 1'b1;
            d.mem.we     = 1'b0;
            d.mem.addr   = q.base + HDR_OFF;
            d.mem.be     = BE_X87A_NOPTR;
            d.fsm        = S_HDR_RD;
          end
        end
        A_FEM_LO:  d.fem[31:0]   = i_wdata;
        A_FEM_HI:  d.fem[63:32]  = i_wdata;
        A_IMSK_LO: d.imask[31:0] = i_wdata;
        A_IMSK_HI: d.imask[63:32] = i_wdata;
        A_BASE:    d.base        = {i_wdata[31:6], 6'h00};
        A_PEEK_IX: d.peek_idx    = i_wdata[5:0];
        default: begin
        end
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        A_CTRL:    d.rdata = {28'h0, prof_en, q.mode64, q.is_save, q.busy};
        A_FEM_LO:  d.rdata = q.fem[31:0];
        A_FEM_HI:  d.rdata = q.fem[63:32];
        A_IMSK_LO: d.rdata = q.imask[31:0];
        A_IMSK_HI: d.rdata = q.imask[63:32];
        A_BASE:    d.rdata = q.base;
        A_SPV_LO:  d.rdata = q.spv[31:0];
        A_SPV_HI:  d.rdata = q.spv[63:32];
        A_PEEK_IX: d.rdata = {26'h0, q.peek_idx};
        A_PEEK_D0: d.rdata = st_pk[31:0];
        A_PEEK_D1: d.rdata = st_pk[63:32];
        A_PEEK_D2: d.rdata = st_pk[95:64];
        A_PEEK_D3: d.rdata = st_pk[127:96];
        default:   d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q     <= '0;
      q.fem <= FEM_RST;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_mem   = q.mem;
  assign o_busy  = q.busy;
  assign o_done  = q.done;

  default clocking cb_clk @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence mcs_line_s;
    q.fsm == S_LINE && !q.is_save && q.line_idx == L_X87B && (q.sel[C_VEC] || q.sel[C_UPR]);
  endsequence

  sequence mcs_read_s;
    q.mem.req && !q.mem.we && q.fsm == S_RD_WAIT && q.mem.be[11:8] == 4'hf;
  endsequence

  header_addr_a: assert property (
    q.mem.req && (q.fsm == S_HDR_RD || q.fsm == S_HDR_WAIT) |-> q.mem.addr == q.base + HDR_OFF)
    else $error("header not at offset 512");

  present_set_a: assert property (
    q.fsm == S_HDR_WAIT && q.mem.req |->
      (q.mem.wdata[63:0] & q.sel & SAVE_COMPS) == (q.sel & SAVE_COMPS))
    else $error("saved component lacks present bit");

  unsel_keep_a: assert property (
    $rose(q.fsm == S_HDR_WAIT) |-> ((q.mem.wdata[63:0] ^ $past(q.spv)) & ~q.sel) == 64'h0)
    else $error("unselected header bit changed");

  restore_gate_a: assert property (
    st_we && !q.is_save && q.line_idx >= L_VEC0 && q.line_idx < L_UPR0 |-> q.sel[C_VEC])
    else $error("vector state written while unselected");

  x87_init_a: assert property (
    st_we && q.fsm == S_LINE && q.line_idx == L_X87A |->
      st_wd[15:0] == FPU_CTRL_INIT && st_be[0] && !q.spv[C_X87])
    else $error("bad x87 init");

  mcs_read_a: assert property (
    mcs_line_s |=> mcs_read_s)
    else $error("media control not read from memory");

  no_ptr_save_a: assert property (
    q.is_save && q.fsm == S_WR_WAIT && q.mem.req && q.line_idx == L_X87A && !st_es |->
      q.mem.be[15:8] == 8'h00)
    else $error("error pointers saved without fault");

  mode_skip_a: assert property (
    q.mem.req && !q.mode64 && (q.fsm == S_RD_WAIT || q.fsm == S_WR_WAIT) |->
      !((q.line_idx >= L_VEC8 && q.line_idx < L_UPR0) || q.line_idx >= L_UPR8))
    else $error("high registers touched outside 64-bit mode");

  fixed_slot_a: assert property (
    $rose(q.mem.req) && q.fsm inside {S_RD_WAIT, S_WR_WAIT} |->
      q.mem.addr == line_addr(q.base, q.line_idx) && q.mem.addr[3:0] == 4'h0)
    else $error("component slot moved");

  prof_off_a: assert property (
    q.fsm == S_LINE && q.line_idx == L_END && !q.is_save && q.sel[C_PROF] && !q.spv[C_PROF]
      |=> !prof_en)
    else $error("profiling left enabled");
endmodule : esr_engine
`default_nettype wire

// ### esr_pkg.sv
// Contract
// - The save area header begins 512 bytes past the start of the save area.
// - The header opens with a 64-bit state-present vector in feature-enable bit order.
// - A save sets the state-present bit of every component that it writes out.
// - A save changes only bits selected by instruction mask AND feature-enable mask.
// - A restore updates a component only when its mask bit and enable bit are both set.
// - A restored component loads from memory if its present bit is set, else takes init values.
// - x87 init is control 037f, status 0, abridged tag 00, zero pointers and zero stack.
// - Vector init zeroes registers 0 to 15 in 64-bit mode and 0 to 7 otherwise.
// - Upper-half init zeroes halves 0 to 15 in 64-bit mode and 0 to 7 otherwise.
// - Media control/status has no init value and is read whenever vector or upper halves restore.
// - x87 error pointers are neither saved nor restored without a pending fpu fault.
// - Outside 64-bit mode vector registers 8 to 15 and their upper halves are not touched.
// - Every component sits at a fixed offset; the area is never compacted.
// - Feature-enable bit 2 is upper vector state, bit 1 vector state, bit 0 x87 state.
package esr_pkg;
  localparam int          LINE_W   = 128;
  localparam int          BE_W     = 16;
  localparam int          NLINES   = 42;
  localparam logic [31:0] HDR_OFF  = 32'h0000_0200;
  localparam logic [31:0] UPPER_OFF_DEF = 32'h0000_0240;
  // Line index inside the core image; memory slot is fixed per index
  localparam logic [5:0]  L_X87A   = 6'h00;
  localparam logic [5:0]  L_X87B   = 6'h01;
  localparam logic [5:0]  L_STK0   = 6'h02;
  localparam logic [5:0]  L_STK7   = 6'h09;
  localparam logic [5:0]  L_VEC0   = 6'h0a;
  localparam logic [5:0]  L_VEC8   = 6'h12;
  localparam logic [5:0]  L_UPR0   = 6'h1a;
  localparam logic [5:0]  L_UPR8   = 6'h22;
  localparam logic [5:0]  L_END    = 6'h2a;
  // Component bits of the feature-enable mask
  localparam int          C_X87    = 0;
  localparam int          C_VEC    = 1;
  localparam int          C_UPR    = 2;
  localparam int          C_PROF   = 62;
  localparam logic [63:0] SAVE_COMPS = 64'h0000_0000_0000_0007;
  localparam logic [63:0] FEM_RST  = 64'h0000_0000_0000_0001;
  localparam logic [15:0] FPU_CTRL_INIT = 16'h037f;
  localparam logic [15:0] FPU_STAT_INIT = 16'h0000;
  localparam logic [7:0]  FPU_TAG_INIT  = 8'h00;
  localparam int          FPU_FAULT_BIT = 7;
  localparam logic [31:0] MCS_MASK_DEF = 32'h0000_ffff;
  // Byte lanes inside one 16-byte line
  localparam logic [15:0] BE_X87A_NOPTR = 16'h00ff;
  localparam logic [15:0] BE_PTR_B  = 16'h00ff;
  localparam logic [15:0] BE_ST     = 16'h03ff;
  localparam logic [15:0] BE_FULL   = 16'hffff;
  localparam logic [15:0] BE_MCS_SV = 16'hff00;
  localparam logic [15:0] BE_MCS_LD = 16'h0f00;
  // Register port offsets
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_FEM_LO  = 8'h04;
  localparam logic [7:0]  A_FEM_HI  = 8'h08;
  localparam logic [7:0]  A_IMSK_LO = 8'h0c;
  localparam logic [7:0]  A_IMSK_HI = 8'h10;
  localparam logic [7:0]  A_BASE    = 8'h14;
  localparam logic [7:0]  A_SPV_LO  = 8'h18;
  localparam logic [7:0]  A_SPV_HI  = 8'h1c;
  localparam logic [7:0]  A_PEEK_IX = 8'h20;
  localparam logic [7:0]  A_PEEK_D0 = 8'h24;
  localparam logic [7:0]  A_PEEK_D1 = 8'h28;
  localparam logic [7:0]  A_PEEK_D2 = 8'h2c;
  localparam logic [7:0]  A_PEEK_D3 = 8'h30;

  typedef enum logic [2:0] {
    S_IDLE, S_HDR_RD, S_LINE, S_RD_WAIT, S_WR_WAIT, S_HDR_WAIT
  } esr_fsm_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [31:0]       addr;
    logic [LINE_W-1:0] wdata;
    logic [BE_W-1:0]   be;
  } esr_mem_req_t;

  typedef struct packed {
    logic [BE_W-1:0] x87;
    logic [BE_W-1:0] vec;
    logic [BE_W-1:0] upr;
    logic [BE_W-1:0] mcs;
  } esr_be_t;

  typedef struct packed {
    esr_fsm_t        fsm;
    logic            is_save;
    logic [5:0]      line_idx;
    logic [63:0]     fem;
    logic [63:0]     imask;
    logic [63:0]     sel;
    logic [63:0]     spv;
    logic [31:0]     base;
    logic            mode64;
    logic [5:0]      peek_idx;
    logic [BE_W-1:0] be_ld;
    logic [BE_W-1:0] be_in;
    logic [31:0]     rdata;
    logic            busy;
    logic            done;
    esr_mem_req_t    mem;
  } esr_st_t;
endpackage : esr_pkg

// ### esr_state_file.sv
`timescale 1ns/1ns
`default_nettype none
module esr_state_file #(
  parameter int NL = 42
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rstn,
  input  wire logic [5:0]               i_rd_idx,
  output logic [esr_pkg::LINE_W-1:0]    o_rd_data,
  input  wire logic [5:0]               i_pk_idx,
  output logic [esr_pkg::LINE_W-1:0]    o_pk_data,
  output logic                          o_fault_pend,
  input  wire logic                     i_wr_en,
  input  wire logic [5:0]               i_wr_idx,
  input  wire logic [esr_pkg::LINE_W-1:0] i_wr_data,
  input  wire logic [esr_pkg::BE_W-1:0] i_wr_be,
  input  wire logic                     i_prof_on,
  input  wire logic                     i_prof_off,
  output logic                          o_prof_en
);
  import esr_pkg::*;

  typedef struct packed {
    logic [NL-1:0][LINE_W-1:0] lines;
    logic                      prof;
  } esr_sf_t;

  esr_sf_t q;
  esr_sf_t d;

  always_comb begin
    d = q;
    if (i_wr_en && (int'(i_wr_idx) < NL)) begin
      for (int b = 0; b < BE_W; b++) begin
        if (i_wr_be[b]) begin
          d.lines[i_wr_idx][b*8 +: 8] = i_wr_data[b*8 +: 8];
        end
      end
    end
    if (i_prof_off) begin
      d.prof = 1'b0;
    end else if (i_prof_on) begin
      d.prof = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    o_rd_data = (int'(i_rd_idx) < NL) ? q.lines[i_rd_idx] : '0;
    o_pk_data = (int'(i_pk_idx) < NL) ? q.lines[i_pk_idx] : '0;
    if (i_rd_idx == L_X87B) begin
      // Mask field is fixed by the hardware, not stored state
      o_rd_data[127:96] = MCS_MASK_DEF;
    end
  end

  assign o_fault_pend = q.lines[0][16+FPU_FAULT_BIT];
  assign o_prof_en    = q.prof;
endmodule : esr_state_file
`default_nettype wire

// ### esr_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module esr_mem_model (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rstn,
  input  wire esr_pkg::esr_mem_req_t      i_mem,
  input  wire logic [3:0]                 i_delay,
  output logic                            o_ack,
  output logic [esr_pkg::LINE_W-1:0]      o_rdata
);
  import esr_pkg::*;
  logic [LINE_W-1:0] mem [0:127];
  logic [3:0]        wait_cnt;
  logic [6:0]        idx;
  assign idx = i_mem.addr[10:4];
  // Read data toggles outside the ack cycle so stale values never look valid
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= '1;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= ~o_rdata;
    end else if (i_mem.req && wait_cnt == i_delay) begin
      o_ack <= 1'b1;
      if (i_mem.we) begin
        o_rdata <= ~o_rdata;
        for (int b = 0; b < BE_W; b++) begin
          if (i_mem.be[b]) begin
            mem[idx][8*b+:8] <= i_mem.wdata[8*b+:8];
          end
        end
      end else begin
        o_rdata <= mem[idx];
      end
    end else begin
      wait_cnt <= i_mem.req ? wait_cnt + 4'h1 : 4'h0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule : esr_mem_model
`default_nettype wire

// ### tb_esr_engine.sv
`timescale 1ns/1ns
`default_nettype none
module tb_esr_engine;
  import esr_pkg::*;
  logic              ref_clk, rstn, wr, rd, ack, busy, done;
  logic [7:0]        addr;
  logic [31:0]       wdata, rdata, w;
  logic [LINE_W-1:0] mrdata, ln, l0a;
  logic [3:0]        dly;
  esr_mem_req_t      mreq;
  int                errors, samples_checked, cycles;

  esr_engine esr_engine_inst (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_mem(mreq),
    .i_mem_ack(ack), .i_mem_rdata(mrdata), .o_busy(busy), .o_done(done));
  esr_mem_model esr_mem_model_inst (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_mem(mreq),
    .i_delay(dly), .o_ack(ack), .o_rdata(mrdata));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk128(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t line got %h exp %h", $time, got, exp);
    end
  endtask : chk128

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic peek(input logic [5:0] ix, output logic [127:0] l);
    logic [31:0] d;
    wr_reg(A_PEEK_IX, {26'h0, ix});
    for (int k = 0; k < 4; k++) begin
      rd_reg(A_PEEK_D0 + 8'(4 * k), d);
      l[32*k+:32] = d;
    end
  endtask : peek

  task automatic wait_done();
    int n;
    n = 0;
    while (n < 3000 && done !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 3000) begin
      errors++;
      $display("[FAIL] %0t no completion", $time);
    end
  endtask : wait_done

  task automatic setup(input logic [31:0] fem, input logic [31:0] msk, input logic [31:0] hi,
                       input logic [31:0] base);
    wr_reg(A_FEM_LO, fem);
    wr_reg(A_FEM_HI, hi);
    wr_reg(A_IMSK_LO, msk);
    wr_reg(A_IMSK_HI, hi);
    wr_reg(A_BASE, base);
  endtask : setup

  function automatic logic [127:0] pat(input int i);
    return {16{8'(i)}};
  endfunction : pat

  task automatic t_reset();
    rd_reg(A_FEM_LO, w);
    chk32(w, FEM_RST[31:0]);
    rd_reg(A_CTRL, w);
    chk32(w, 32'h0000_0000);
    rd_reg(8'h34, w);
    chk32(w, 32'h0000_0000);
  endtask : t_reset

  task automatic t_rst_load();
    for (int i = 0; i < 128; i++) esr_mem_model_inst.mem[i] = pat(i);
    l0a = {64'h1122_3344_5566_7788, 16'h0000, 8'h00, 8'h5a, 16'h0080, 16'h1234};
    esr_mem_model_inst.mem[0] = l0a;
    esr_mem_model_inst.mem[1] = {32'h0, 32'h0000_1f80, 64'h99aa_bbcc_ddee_ff00};
    esr_mem_model_inst.mem[32] = {64'h0, 64'h7};
    setup(32'h7, 32'h7, 32'h0, 32'h0);
    wr_reg(A_CTRL, 32'h6);
    wait_done();
    rd_reg(A_SPV_LO, w);
    chk32(w, 32'h7);
    peek(L_X87A, ln);
    chk128(ln, l0a);
    peek(L_X87B, ln);
    chk32(ln[95:64], 32'h0000_1f80);
    peek(6'd25, ln);
    chk128(ln, pat(25));
    peek(6'd41, ln);
    chk128(ln, pat(51));
  endtask : t_rst_load

  task automatic t_rst_keep_ptr();
    esr_mem_model_inst.mem[0] = {64'hdead_0000_beef_0000, 32'h0000_1100, 32'h0000_0aaa};
    esr_mem_model_inst.mem[25] = pat(99);
    esr_mem_model_inst.mem[32] = {64'h0, 64'h1};
    setup(32'h7, 32'h1, 32'h0, 32'h0);
    wr_reg(A_CTRL, 32'h6);
    wait_done();
    peek(L_X87A, ln);
    chk128(ln, {l0a[127:64], 64'h0000_1100_0000_0aaa});
    peek(6'd25, ln);
    chk128(ln, pat(25));
  endtask : t_rst_keep_ptr

  task automatic t_rst_init();
    esr_mem_model_inst.mem[1] = {32'h0, 32'h0000_1fc0, 64'h1};
    esr_mem_model_inst.mem[32] = {64'h0, 64'h0};
    setup(32'h7, 32'h7, 32'h4000_0000, 32'h0);
    wr_reg(A_CTRL, 32'h8);
    rd_reg(A_CTRL, w);
    chk32(w & 32'h8, 32'h8);
    wr_reg(A_CTRL, 32'h2);
    wait_done();
    peek(L_X87A, ln);
    chk128({ln[127:64], 16'h0, ln[47:0]}, {112'h0, FPU_CTRL_INIT});
    peek(L_X87B, ln);
    chk128({32'h0, ln[95:0]}, {64'h0000_1fc0, 64'h0});
    for (int k = 0; k < 8; k++) begin
      peek(L_VEC0 + 6'(k), ln);
      chk128(ln, 128'h0);
      peek(L_UPR0 + 6'(k), ln);
      chk128(ln, 128'h0);
    end
    peek(L_VEC8, ln);
    chk128(ln, pat(18));
    peek(L_UPR8, ln);
    chk128(ln, pat(44));
    rd_reg(A_CTRL, w);
    chk32(w & 32'he, 32'h0);
  endtask : t_rst_init

  // Plain save last, into a second area that the restore operations never access; t_rst_load fills it
  task automatic t_save();
    esr_mem_model_inst.mem[96] = {{8{8'h60}}, 64'hf0};
    dly = 4'h3;
    setup(32'h3, 32'h5, 32'h0, 32'h400);
    wr_reg(A_CTRL, 32'h1);
    wr_reg(A_FEM_LO, 32'h0);
    chk32({31'h0, busy}, 32'h1);
    wait_done();
    rd_reg(A_FEM_LO, w);
    chk32(w, 32'h3);
    chk128(esr_mem_model_inst.mem[96], {{8{8'h60}}, 64'hf1});
    ln = esr_mem_model_inst.mem[64];
    chk128({ln[127:64], ln[47:0]}, {{8{8'h40}}, 32'h0, FPU_CTRL_INIT});
    chk128(esr_mem_model_inst.mem[65], pat(65));
    chk128(esr_mem_model_inst.mem[66], {{6{8'h42}}, 80'h0});
    chk128(esr_mem_model_inst.mem[74], pat(74));
    rd_reg(A_SPV_HI, w);
    chk32(w, 32'h0);
    rd_reg(A_CTRL, w);
    chk32(w & 32'h3, 32'h2);
  endtask : t_save

  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    dly = 4'h0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_rst_load();
    t_rst_keep_ptr();
    t_rst_init();
    t_save();
    end_sim();
  end
endmodule : tb_esr_engine
`default_nettype wire
